//--- verilog/lrpf_pkg.sv
// Purpose: Shared constants, types and sizing arithmetic for the link receive
//          phase recovery FIFO.
// Assumes: Synchronous clocking; link and core clocks share one time base.
// Notes:   Phase budgets are in picoseconds, rates in mega-transfers per second.
package lrpf_pkg;

    // ------------------------------------------------------------------
    // Lane layout
    // ------------------------------------------------------------------
    localparam int CAD_W  = 8;
    localparam int WORD_W = CAD_W + 1;

    typedef struct packed {
        logic             link_control;
        logic [CAD_W-1:0] command_address_data;
    } lrpf_word_t;

    // ------------------------------------------------------------------
    // Phase error budget, picoseconds
    // ------------------------------------------------------------------
    localparam int REFCLK_PHASE_PS         = 733;
    localparam int TX_PLL_PHASE_BUDGET_PS  = 3500;
    localparam int RX_PLL_PHASE_BUDGET_PS  = 3500;
    localparam int LANE_VAR_SKEW_PS        = 250;
    localparam int LANE_CONST_SKEW_PS      = 1000;
    localparam int PS_PER_US               = 1000000;

    // ------------------------------------------------------------------
    // Core clock and synchroniser figures
    // ------------------------------------------------------------------
    localparam int CORE_CLK_MHZ    = 125;
    localparam int CORE_PERIOD_PS  = PS_PER_US / CORE_CLK_MHZ;
    localparam int SYNC_STAGES     = 3;
    localparam int SYNC_DELAY_PS   = (SYNC_STAGES + 1) * CORE_PERIOD_PS;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic RST_INIT_SEEN = 1'b0;
    localparam logic RST_PTR_SET   = 1'b0;
    localparam logic RST_SLIP      = 1'b0;
    localparam int   RST_PTR       = 0;

    // Transmitter and interconnect transfer error per link rate
    function automatic int tx_transfer_ps(input int mts);
        case (mts)
            400:     return 918;
            600:     return 592;
            800:     return 469;
            1000:    return 358;
            1200:    return 295;
            1600:    return 228;
            default: return 918;
        endcase
    endfunction

    // Receiver package and clock distribution error per link rate
    function automatic int rx_transfer_ps(input int mts);
        case (mts)
            400:     return 425;
            600:     return 250;
            800:     return 188;
            1000:    return 130;
            1200:    return 109;
            1600:    return 81;
            default: return 425;
        endcase
    endfunction

    function automatic int ceil_div(input int num, input int den);
        return (num + den - 1) / den;
    endfunction

    // Least read-to-write separation in picoseconds
    function automatic int min_sep_ps(input int mts);
        int variant;
        variant = REFCLK_PHASE_PS + TX_PLL_PHASE_BUDGET_PS + tx_transfer_ps(mts)
                + LANE_VAR_SKEW_PS + RX_PLL_PHASE_BUDGET_PS + rx_transfer_ps(mts);
        return variant + CORE_PERIOD_PS + LANE_CONST_SKEW_PS / 2;
    endfunction

endpackage

//--- verilog/lrpf_sync.sv
// Purpose: Three-stage synchroniser with agreement filter, one lane per bit.
// Assumes: Each bit is a level that holds for several destination clocks.
// Notes:   The first stage feeds the second stage only.
`timescale 1ns/1ps
`default_nettype none
module lrpf_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Levels
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);

    // ------------------------------------------------------------------
    // Per-bit stages
    // ------------------------------------------------------------------
    generate
        for (genvar b = 0; b < WIDTH; b++) begin : g_bit
            logic stage1;
            logic stage2;
            logic stage3;
            // A change is accepted only once stages two and three agree
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    stage1       <= 1'b0;
                    stage2       <= 1'b0;
                    stage3       <= 1'b0;
                    level_out[b] <= 1'b0;
                end else begin
                    stage1 <= level_in[b];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3) begin
                        level_out[b] <= stage3;
                    end
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

//--- verilog/lrpf_line_pack.sv
// Purpose: Gathers link words into one core-width line on the link clock.
// Assumes: One word arrives on every link clock edge.
// Notes:   Align restarts the line so that the marker word opens a line.
`timescale 1ns/1ps
`default_nettype none
module lrpf_line_pack #(
    parameter int WORDS = 1
) (
    // Link clock and reset
    input  wire logic                            clk_in,
    input  wire logic                            rst_in,
    // Word stream
    input  wire logic                            align_in,
    input  wire lrpf_pkg::lrpf_word_t            word_in,
    // Line stream
    output logic [WORDS*lrpf_pkg::WORD_W-1:0]    line_out,
    output logic                                 line_we_out
);
    import lrpf_pkg::*;

    localparam int CW = (WORDS > 1) ? $clog2(WORDS) : 1;
    localparam logic [CW-1:0] LAST = CW'(WORDS - 1);

    logic [CW-1:0]           slot;
    logic [WORDS*WORD_W-1:0] gather;
    wire  [CW-1:0]           this_slot = align_in ? '0 : slot;
    wire                     closes    = (this_slot == LAST);

    // ------------------------------------------------------------------
    // Gathering
    // ------------------------------------------------------------------
    // The completed line is copied out so that the writer never sees a
    // half-filled line
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            slot        <= '0;
            gather      <= '0;
            line_out    <= '0;
            line_we_out <= 1'b0;
        end else begin
            gather[this_slot*WORD_W +: WORD_W] <= word_in;
            slot        <= closes ? '0 : CW'(this_slot + 1'b1);
            line_we_out <= closes;
            if (closes) begin
                line_out <= gather;
                line_out[this_slot*WORD_W +: WORD_W] <= word_in;
            end
        end
    end

endmodule
`default_nettype wire

//--- verilog/lrpf_top.sv
// Purpose: Receive phase recovery FIFO, link clock to core clock.
// Assumes: Synchronous clocking; peer forwards its clock without pause.
// Notes:   Depth and initial separation come from the phase budget at the
//          link rate given by LINK_MTS.
// Functional notes
// - Read pointer set only after control and data lanes are seen low in core.
// - Separation holds with an early first edge and late later edges.
// - Overwrite margin holds with a late first edge and early later edges.
// - Depth covers twice the dynamic variation from temperature, voltage, noise.
// - Pointer placement tolerates one core clock early or late.
// - Width translation adds locations so whole lines are safely written and read.
// - Lane clock skew is added to the write clock uncertainty.
// - Own synchroniser delay is credited back to the initial read pointer.
// - Budget allows 733 ps reference clock phase error.
// - Budget allows 3500 ps each for transmit and receive PLL error.
// - Budget allows transmit transfer error, 918 ps down to 228 ps.
// - Budget allows 250 ps variable and 1000 ps constant lane skew.
// - Budget allows receive transfer error, 425 ps down to 81 ps.
// - Separation exceeds variant errors plus one core bit plus half constant skew.
// - Span exceeds twice separation plus one bit; lines round up.
// - Written on the forwarded link clock, read on the core clock.
// - Read pointer placed once at initialization, never adjusted later.
`timescale 1ns/1ps
`default_nettype none
module lrpf_top #(
    parameter int LINK_MTS       = 400,
    parameter int WORDS_PER_LINE = 1
) (
    // Core clock and reset
    input  wire logic                                     clk_in,
    input  wire logic                                     rst_in,
    // Link side, forwarded clock domain
    input  wire logic                                     link_write_clock,
    input  wire logic                                     link_control_in,
    input  wire logic [lrpf_pkg::CAD_W-1:0]               command_address_data_in,
    // Core read side
    input  wire logic                                     read_req_in,
    output logic                                          read_ready_out,
    output logic      [WORDS_PER_LINE*lrpf_pkg::WORD_W-1:0] line_out,
    output logic                                          line_valid_out,
    // Status
    output logic                                          lanes_low_out,
    output logic                                          slip_out
);
    import lrpf_pkg::*;

    // ------------------------------------------------------------------
    // Sizing from the phase budget
    // ------------------------------------------------------------------
    localparam int LINE_W     = WORDS_PER_LINE * WORD_W;
    localparam int BIT_PS     = PS_PER_US / LINK_MTS;
    // Variant errors, one core bit of sampling error and half constant skew
    localparam int SEP_PS     = min_sep_ps(LINK_MTS);
    // Twice the separation covers both first-edge extremes
    localparam int SPAN_PS    = 2 * SEP_PS + BIT_PS;
    localparam int SEP_WORDS  = ceil_div(SEP_PS, BIT_PS);
    // Extra words on both sides so a line is complete before and after reading
    localparam int SPAN_WORDS = ceil_div(SPAN_PS, BIT_PS)
                              + 2 * (WORDS_PER_LINE - 1);
    localparam int LINES      = ceil_div(SPAN_WORDS, WORDS_PER_LINE);
    localparam int AW         = (LINES > 2) ? $clog2(LINES) : 1;
    localparam int DEPTH      = 1 << AW;
    localparam int SEP_LINES  = ceil_div(SEP_WORDS, WORDS_PER_LINE)
                              + ((WORDS_PER_LINE > 1) ? 1 : 0);
    // Synchroniser delay in lines, rounded down so it never eats margin
    localparam int SYNC_LINES = SYNC_DELAY_PS / (BIT_PS * WORDS_PER_LINE);

    localparam logic [AW-1:0] SEP_LINES_P  = AW'(SEP_LINES);
    localparam logic [AW-1:0] SYNC_LINES_P = AW'(SYNC_LINES);
    localparam logic [AW-1:0] PTR_RESET    = AW'(RST_PTR);

    // Refuse settings the pointer arithmetic cannot serve
    generate
        if (WORDS_PER_LINE < 1 || LINK_MTS < 1 || BIT_PS < 1) begin : g_bad_param
            $error("lrpf_top: link rate and line width must be positive");
        end
        // The sync credit wraps modulo depth; only the separation must fit
        if (SEP_LINES >= DEPTH) begin : g_bad_depth
            $error("lrpf_top: separation does not fit the derived depth");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [AW-1:0] to_gray(input logic [AW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [AW-1:0] from_gray(input logic [AW-1:0] g);
        logic [AW-1:0] b;
        b = '0;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = g[i] ^ ((i == AW - 1) ? 1'b0 : b[i + 1]);
        end
        return b;
    endfunction

    // ------------------------------------------------------------------
    // Storage, written on the link clock, read on the core clock
    // ------------------------------------------------------------------
    logic [LINE_W-1:0] mem [DEPTH];

    // ------------------------------------------------------------------
    // Link domain reset release
    // ------------------------------------------------------------------
    logic link_rst_s1;
    logic link_rst;

    // Assert at once, release only on a link edge so no write is torn
    always_ff @(posedge link_write_clock or posedge rst_in) begin
        if (rst_in) begin
            link_rst_s1 <= 1'b1;
            link_rst    <= 1'b1;
        end else begin
            link_rst_s1 <= 1'b0;
            link_rst    <= link_rst_s1;
        end
    end

    // ------------------------------------------------------------------
    // Link domain sampling and initial transition
    // ------------------------------------------------------------------
    lrpf_word_t    link_word;
    logic          init_seen;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] wr_gray;
    logic [AW-1:0] mark_ptr;

    // Lanes are captured on their own forwarded clock, no synchroniser
    always_ff @(posedge link_write_clock or posedge link_rst) begin
        if (link_rst) begin
            link_word <= '0;
        end else begin
            link_word.link_control         <= link_control_in;
            link_word.command_address_data <= command_address_data_in;
        end
    end

    // First all-low sample after reset; the peer keeps lanes low meanwhile
    wire lanes_low_link = (link_word.link_control == 1'b0)
                        && (link_word.command_address_data == '0);
    wire first_low      = lanes_low_link && !init_seen;

    // Mark the line that opens with the first low word
    always_ff @(posedge link_write_clock or posedge link_rst) begin
        if (link_rst) begin
            init_seen <= RST_INIT_SEEN;
            mark_ptr  <= PTR_RESET;
        end else if (first_low) begin
            init_seen <= 1'b1;
            mark_ptr  <= wr_ptr;
        end
    end

    // ------------------------------------------------------------------
    // Line gathering and write pointer
    // ------------------------------------------------------------------
    logic [LINE_W-1:0] packed_line;
    logic              packed_we;

    lrpf_line_pack #(
        .WORDS       (WORDS_PER_LINE)
    ) u_pack (
        .clk_in      (link_write_clock),
        .rst_in      (link_rst),
        .align_in    (first_low),
        .word_in     (link_word),
        .line_out    (packed_line),
        .line_we_out (packed_we)
    );

    wire [AW-1:0] next_wr_ptr = AW'(wr_ptr + 1'b1);

    // Pointer steps one line per completed line and wraps at depth
    always_ff @(posedge link_write_clock or posedge link_rst) begin
        if (link_rst) begin
            wr_ptr  <= PTR_RESET;
            wr_gray <= to_gray(PTR_RESET);
        end else if (packed_we) begin
            wr_ptr  <= next_wr_ptr;
            wr_gray <= to_gray(next_wr_ptr);
        end
    end

    // Storage has no reset; the first reads after placement can return lines not yet written since reset
    always_ff @(posedge link_write_clock) begin
        if (packed_we) begin
            mem[wr_ptr] <= packed_line;
        end
    end

    // ------------------------------------------------------------------
    // Crossing into the core clock
    // ------------------------------------------------------------------
    logic          init_core;
    logic [AW-1:0] wr_gray_core;

    // The marker is held steady once raised, so the level qualifies it
    lrpf_sync #(
        .WIDTH     (1)
    ) u_sync_init (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .level_in  (init_seen),
        .level_out (init_core)
    );

    // Gray coding keeps every pointer step a single-bit change
    lrpf_sync #(
        .WIDTH     (AW)
    ) u_sync_wptr (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .level_in  (wr_gray),
        .level_out (wr_gray_core)
    );

    // ------------------------------------------------------------------
    // Read pointer placement and reads
    // ------------------------------------------------------------------
    logic          ptr_set;
    logic [AW-1:0] rd_ptr;

    // Writer has run on by roughly the sync delay since the mark, so the
    // delay is credited back before stepping back by the separation
    wire [AW-1:0] next_rd_init = AW'(mark_ptr + SYNC_LINES_P - SEP_LINES_P);
    wire          place_now    = init_core && !ptr_set;
    wire          do_read      = ptr_set && read_req_in;
    wire [AW-1:0] next_rd_ptr  = AW'(rd_ptr + 1'b1);

    // Placed once; afterwards only reads move it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_set <= RST_PTR_SET;
            rd_ptr  <= PTR_RESET;
        end else if (place_now) begin
            ptr_set <= 1'b1;
            rd_ptr  <= next_rd_init;
        end else if (do_read) begin
            rd_ptr  <= next_rd_ptr;
        end
    end

    // Line out is registered; valid pulses for one core cycle per read
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            line_out       <= '0;
            line_valid_out <= 1'b0;
        end else begin
            line_valid_out <= do_read;
            if (do_read) begin
                line_out <= mem[rd_ptr];
            end
        end
    end

    // ------------------------------------------------------------------
    // Separation watch
    // ------------------------------------------------------------------
    // The seen write pointer lags, so a zero fill can flag a catch-up while
    // the writer is still ahead; the pointer is still not adjusted
    wire [AW-1:0] wr_seen = from_gray(wr_gray_core);
    wire [AW-1:0] fill    = AW'(wr_seen - rd_ptr);
    wire          caught  = ptr_set && (fill == '0);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            slip_out <= RST_SLIP;
        end else if (caught) begin
            slip_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    assign read_ready_out = ptr_set;
    assign lanes_low_out  = init_core;

endmodule
`default_nettype wire

//--- tb/lrpf_properties.sv
// Purpose: Port-level timing checks for the receive phase FIFO.
// Assumes: Checks run on the core clock; link lanes are slow levels.
// Notes:   Bound to every lrpf_top instance.
`timescale 1ns/1ps
`default_nettype none
module lrpf_properties #(
    parameter int LINK_MTS       = 400,
    parameter int WORDS_PER_LINE = 1
) (
    // Clocks and reset
    input wire logic                                       clk_in,
    input wire logic                                       rst_in,
    input wire logic                                       link_write_clock,
    // Link lanes
    input wire logic                                       link_control_in,
    input wire logic [lrpf_pkg::CAD_W-1:0]                 command_address_data_in,
    // Read side and status
    input wire logic                                       read_req_in,
    input wire logic                                       read_ready_out,
    input wire logic [WORDS_PER_LINE*lrpf_pkg::WORD_W-1:0] line_out,
    input wire logic                                       line_valid_out,
    input wire logic                                       lanes_low_out,
    input wire logic                                       slip_out
);
    import lrpf_pkg::*;
    // ------------------------------------------------------------------
    // Idle lane timer
    // ------------------------------------------------------------------
    // Saturates so a long idle link never wraps back to a small count
    wire        lanes_idle = !link_control_in && (command_address_data_in == '0);
    logic [6:0] idle_cnt;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) idle_cnt <= 7'h00;
        else if (!lanes_idle) idle_cnt <= 7'h00;
        else if (idle_cnt != 7'h7f) idle_cnt <= idle_cnt + 7'h01;
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_read_answer; read_req_in && read_ready_out |=> line_valid_out; endproperty
    property p_no_stray; line_valid_out |-> $past(read_req_in && read_ready_out); endproperty
    property p_ready_holds; read_ready_out |=> read_ready_out; endproperty
    property p_low_holds; lanes_low_out |=> lanes_low_out; endproperty
    property p_ready_after_low; $rose(read_ready_out) |-> $past(lanes_low_out); endproperty
    property p_line_holds; !(read_req_in && read_ready_out) |=> $stable(line_out); endproperty
    property p_slip_holds; slip_out |=> slip_out; endproperty
    property p_init_bound; idle_cnt == 7'd40 |-> read_ready_out; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    a_no_stray: assert property (p_no_stray) else $error("valid without read");
    a_ready_holds: assert property (p_ready_holds) else $error("ready dropped");
    a_low_holds: assert property (p_low_holds) else $error("low flag dropped");
    a_ready_after_low: assert property (p_ready_after_low) else $error("ready early");
    a_line_holds: assert property (p_line_holds) else $error("line moved");
    a_slip_holds: assert property (p_slip_holds) else $error("slip cleared");
    a_init_bound: assert property (p_init_bound) else $error("no pointer setup");
    c_read: cover property (read_req_in && read_ready_out ##1 line_valid_out);
    c_ready: cover property ($rose(read_ready_out));
    c_refused: cover property (read_req_in && !read_ready_out);
endmodule
bind lrpf_top lrpf_properties #(.LINK_MTS(LINK_MTS), .WORDS_PER_LINE(WORDS_PER_LINE)) u_props (
    .clk_in(clk_in), .rst_in(rst_in), .link_write_clock(link_write_clock),
    .link_control_in(link_control_in), .command_address_data_in(command_address_data_in),
    .read_req_in(read_req_in), .read_ready_out(read_ready_out), .line_out(line_out),
    .line_valid_out(line_valid_out), .lanes_low_out(lanes_low_out), .slip_out(slip_out)
);
`default_nettype wire

//--- tb/lrpf_peer_tx.sv
// Purpose: Peer transmitter: forwards a free-running clock and a word count.
// Assumes: Same time base as the core clock, 48 ns link period.
// Notes:   Lanes stay low until send_in, then count up from 1 with control set.
`timescale 1ns/1ps
`default_nettype none
module lrpf_peer_tx (
    // Control
    input  wire logic                        rst_in,
    input  wire logic                        send_in,
    // Link
    output logic                             link_clock_out,
    output logic                             link_control_out,
    output logic [lrpf_pkg::CAD_W-1:0]       data_out
);
    import lrpf_pkg::*;
    logic [CAD_W-1:0] count;
    // Clock never pauses; the odd offset keeps it out of phase with the core
    initial begin
        link_clock_out = 1'b0;
        link_control_out = 1'b0;
        data_out = '0;
        count = 8'h01;
        #3.3;
        forever #24 link_clock_out = ~link_clock_out;
    end
    // Lanes change on the falling edge so the rising edge samples mid-eye
    always @(posedge rst_in or negedge link_clock_out) begin
        if (rst_in || !send_in) begin
            link_control_out <= 1'b0;
            data_out <= '0;
            if (rst_in) count <= 8'h01;
        end else begin
            link_control_out <= 1'b1;
            data_out <= count;
            count <= count + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- tb/lrpf_top_tb_top.sv
// Purpose: Self-checking bench for the receive phase recovery FIFO.
// Assumes: Core 8 ns, link 48 ns, so reads every 6 cycles keep pace.
// Notes:   Budget rows first, then reset, refusal, streaming, mid-run reset.
`timescale 1ns/1ps
`default_nettype none
module lrpf_top_tb_top;
    import lrpf_pkg::*;
    typedef struct {int mts; int tx; int rx;} lrpf_row_t;
    localparam int CORE_BIT_PS = 8 * 1000;
    lrpf_row_t rows[6] = '{'{400, 918, 425}, '{600, 592, 250}, '{800, 469, 188},
                           '{1000, 358, 130}, '{1200, 295, 109}, '{1600, 228, 81}};
    logic              clk_in, rst_in, read_req_in, send;
    logic              link_clk, link_ctl, ready, valid, low, slip;
    logic [CAD_W-1:0]  link_cad;
    logic [WORD_W-1:0] line;
    logic [WORD_W-1:0] q[40];
    int                n_mismatch, compares, first;
    lrpf_top dut (.clk_in(clk_in), .rst_in(rst_in), .link_write_clock(link_clk),
        .link_control_in(link_ctl), .command_address_data_in(link_cad),
        .read_req_in(read_req_in), .read_ready_out(ready), .line_out(line),
        .line_valid_out(valid), .lanes_low_out(low), .slip_out(slip));
    lrpf_peer_tx peer (.rst_in(rst_in), .send_in(send), .link_clock_out(link_clk),
        .link_control_out(link_ctl), .data_out(link_cad));
    // ------------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------------
    task automatic report(input string what);
        n_mismatch++;
        $display("Error at %0t: %s", $time, what);
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) report(what);
    endtask
    task automatic chk_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        compares++;
        if (got !== exp) report("line content");
    endtask
    task automatic chk_int(input int got, input int exp);
        compares++;
        if (got != exp) report("budget figure");
    endtask
    task automatic close_out;
        $display("Mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One read handshake, six cycles long to match the link word rate
    task automatic rd(output logic [WORD_W-1:0] v);
        read_req_in <= 1'b1;
        @(posedge clk_in);
        read_req_in <= 1'b0;
        #1;
        chk_bit(valid, 1'b1, "valid missing");
        v = line;
        repeat (5) @(posedge clk_in);
    endtask
    // Wait for pointer setup, then read 40 lines while the peer starts sending
    task automatic run_stream;
        for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk_in);
        chk_bit(ready, 1'b1, "ready late");
        chk_bit(low, 1'b1, "low flag");
        first = -1;
        for (int i = 0; i < 40; i++) begin
            if (i == 4) send <= 1'b1;
            rd(q[i]);
            if (first < 0 && q[i] === {1'b1, 8'h01}) first = i;
        end
        chk_bit(first >= 0, 1'b1, "no data seen");
        for (int j = (first < 0 ? 40 : first); j < 40; j++) chk_word(q[j], {1'b1, 8'(j - first + 1)});
        chk_bit(slip, 1'b0, "slip seen");
    endtask
    // ------------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        #100000;
        report("timeout");
        close_out();
    end
    initial begin
        rst_in = 1'b1;
        read_req_in = 1'b0;
        send = 1'b0;
        n_mismatch = 0;
        compares = 0;
        foreach (rows[i]) begin
            chk_int(tx_transfer_ps(rows[i].mts), rows[i].tx);
            chk_int(rx_transfer_ps(rows[i].mts), rows[i].rx);
            chk_int(min_sep_ps(rows[i].mts), 733 + 3500 + rows[i].tx + 250 + 3500 + rows[i].rx
                    + CORE_BIT_PS + 1000 / 2);
        end
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        read_req_in <= 1'b1;
        repeat (4) begin
            @(posedge clk_in);
            #1;
            chk_bit(valid, 1'b0, "read taken early");
        end
        @(posedge clk_in);
        read_req_in <= 1'b0;
        run_stream();
        rst_in <= 1'b1;
        send <= 1'b0;
        repeat (12) @(posedge clk_in);
        #1;
        chk_bit(ready | low | valid | slip, 1'b0, "outputs in reset");
        @(posedge clk_in);
        rst_in <= 1'b0;
        run_stream();
        close_out();
    end
endmodule
`default_nettype wire
